// ---- hdl/external_memory_bus_port.sv ----
// External memory bus port: request side on clk, memory bus on the processor clock.
// Assumes one outstanding request at a time and a 16-bit SDRAM or static parts on the bus.
//
// Notes on behaviour
// - Drive the 25-bit memory address bus on every external access.
// - SDRAM address bits 0..11 travel on device address bits 1..12.
// - Drive the 16-bit data bus on writes, sample it on reads.
// - Data bits map one-to-one onto SDRAM data bits, no swapping.
// - Forward the processor clock as the memory clock, same frequency.
// - Static reads pull the active-low read strobe; never for SDRAM.
// - Static writes pull the active-low write strobe; never for SDRAM.
// - Five active-low static selects, only the chosen one asserted.
// - Byte lane bit 0 masks the low byte, bit 1 the high byte.
// - SDRAM commands ride row strobe, column strobe and read-not-write, registered.
// - Read-not-write low with row strobe high and column strobe low means an SDRAM write command.
// - Memory side stays idle 2 ms after reset release.
`timescale 1ns/1ps
`default_nettype none

module external_memory_bus_port
	import ext_mem_pkg::*;
#(
	parameter int READY_WAIT = READY_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire mem_req_t req,
	output logic req_ready,
	output logic resp_valid,
	output logic [15:0] resp_rdata,
	output logic mem_ready,
	input wire logic proc_clock_in,
	output logic proc_clock_out,
	output logic [24:0] mem_addr,
	input wire logic [15:0] mem_data_in,
	output logic [15:0] mem_data_out,
	output logic mem_data_oe,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic read_not_write,
	output logic static_read_n,
	output logic static_write_n,
	output logic [4:0] static_select_n,
	output logic [1:0] byte_lane_select
);

	typedef enum logic [3:0] {
		ST_POWER, ST_PRECH, ST_INIT_REF, ST_MODE, ST_IDLE,
		ST_ACTIVATE, ST_RD_LAT, ST_STATIC, ST_RECOVER
	} link_state_t;

	// The memory clock is the processor clock passed straight through, so no gate or flop skews it.
	assign proc_clock_out = proc_clock_in;

	logic srst_s1_r, srst_n_r, lrst_s1_r, lrst_n_r;

	// Request side state.
	mem_req_t hold_r, hold_nxt;
	logic req_tgl_r, req_tgl_nxt, busy_r, busy_nxt, ack_seen_r, ack_seen_nxt;
	logic req_ready_r, req_ready_nxt, resp_valid_r, resp_valid_nxt, mem_ready_r, mem_ready_nxt;
	logic [15:0] resp_rdata_r, resp_rdata_nxt;
	logic ack_s1_r, ack_s2_r, ack_s3_r, rdy_s1_r, rdy_s2_r, rdy_s3_r;

	// Memory side state.
	link_state_t st_r, st_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [REF_W-1:0] ref_cnt_r, ref_cnt_nxt;
	logic [3:0] ninit_r, ninit_nxt;
	logic due_r, due_nxt, ready_r, ready_nxt, ack_r, ack_nxt, seen_r, seen_nxt, rd_pend_r, rd_pend_nxt;
	sdram_cmd_t cmd_r, cmd_nxt;
	logic [24:0] addr_r, addr_nxt;
	logic [15:0] dout_r, dout_nxt, rdata_r, rdata_nxt;
	logic doe_r, doe_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
	logic [4:0] cs_n_r, cs_n_nxt;
	logic [1:0] bls_r, bls_nxt;
	logic req_s1_r, req_s2_r, req_s3_r;

	// Reset release and the toggle and level crossings, one set per domain; each first stage feeds only its second.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			srst_s1_r <= 1'b0;
			srst_n_r <= 1'b0;
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			ack_s3_r <= 1'b0;
			rdy_s1_r <= 1'b0;
			rdy_s2_r <= 1'b0;
			rdy_s3_r <= 1'b0;
		end else begin
			srst_s1_r <= 1'b1;
			srst_n_r <= srst_s1_r;
			ack_s1_r <= ack_r;
			ack_s2_r <= ack_s1_r;
			ack_s3_r <= ack_s2_r;
			rdy_s1_r <= ready_r;
			rdy_s2_r <= rdy_s1_r;
			rdy_s3_r <= rdy_s2_r;
		end
	end
	always_ff @(posedge proc_clock_in or negedge rst_n) begin
		if (!rst_n) begin
			lrst_s1_r <= 1'b0;
			lrst_n_r <= 1'b0;
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			req_s3_r <= 1'b0;
		end else begin
			lrst_s1_r <= 1'b1;
			lrst_n_r <= lrst_s1_r;
			req_s1_r <= req_tgl_r;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
		end
	end

	always_comb begin
		logic take, ack_new;
		take = req_valid && req_ready_r;
		ack_new = (ack_s2_r == ack_s3_r) && (ack_s3_r != ack_seen_r);
		hold_nxt = take ? req : hold_r;
		req_tgl_nxt = take ? ~req_tgl_r : req_tgl_r;
		ack_seen_nxt = ack_new ? ack_s3_r : ack_seen_r;
		busy_nxt = take || (busy_r && !ack_new);
		resp_valid_nxt = ack_new;
		// The read word is held still on the memory side until the next request, so it is safe to take here.
		resp_rdata_nxt = ack_new ? rdata_r : resp_rdata_r;
		mem_ready_nxt = (rdy_s2_r == rdy_s3_r) ? rdy_s3_r : mem_ready_r;
		req_ready_nxt = mem_ready_nxt && !busy_nxt;
	end

	always_ff @(posedge clk or negedge srst_n_r) begin
		if (!srst_n_r) begin
			hold_r <= '0;
			req_tgl_r <= 1'b0;
			ack_seen_r <= 1'b0;
			busy_r <= 1'b0;
			resp_valid_r <= 1'b0;
			resp_rdata_r <= DATA_RESET;
			mem_ready_r <= 1'b0;
			req_ready_r <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
			req_tgl_r <= req_tgl_nxt;
			ack_seen_r <= ack_seen_nxt;
			busy_r <= busy_nxt;
			resp_valid_r <= resp_valid_nxt;
			resp_rdata_r <= resp_rdata_nxt;
			mem_ready_r <= mem_ready_nxt;
			req_ready_r <= req_ready_nxt;
		end
	end

	assign req_ready = req_ready_r;
	assign resp_valid = resp_valid_r;
	assign resp_rdata = resp_rdata_r;
	assign mem_ready = mem_ready_r;

	always_comb begin
		logic new_req;
		new_req = (req_s2_r == req_s3_r) && (req_s3_r != seen_r);
		st_nxt = st_r;
		cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
		ref_cnt_nxt = (ref_cnt_r == '0) ? REF_W'(REFRESH_CYCLES - 1) : ref_cnt_r - 1'b1;
		due_nxt = due_r || (ready_r && ref_cnt_r == '0);
		ninit_nxt = ninit_r;
		ready_nxt = ready_r;
		ack_nxt = ack_r;
		seen_nxt = seen_r;
		rd_pend_nxt = rd_pend_r;
		cmd_nxt = CMD_NOP;
		addr_nxt = addr_r;
		dout_nxt = dout_r;
		doe_nxt = 1'b0;
		rd_n_nxt = 1'b1;
		wr_n_nxt = 1'b1;
		cs_n_nxt = SELECT_IDLE;
		bls_nxt = bls_r;
		rdata_nxt = rdata_r;
		unique case (st_r)
			ST_POWER: if (cnt_r == '0) begin
				cmd_nxt = CMD_PRECHARGE;
				addr_nxt = sdram_addr(12'h400, 2'h0);
				cnt_nxt = CNT_W'(RP_CYCLES - 1);
				st_nxt = ST_PRECH;
			end
			ST_PRECH: if (cnt_r == '0) begin
				cmd_nxt = CMD_REFRESH;
				cnt_nxt = CNT_W'(RFC_CYCLES - 1);
				ninit_nxt = 4'(INIT_REFRESHES - 1);
				st_nxt = ST_INIT_REF;
			end
			ST_INIT_REF: if (cnt_r == '0) begin
				if (ninit_r == '0) begin
					cmd_nxt = CMD_MODE;
					addr_nxt = sdram_addr(MODE_WORD, 2'h0);
					cnt_nxt = CNT_W'(MRD_CYCLES - 1);
					st_nxt = ST_MODE;
				end else begin
					cmd_nxt = CMD_REFRESH;
					ninit_nxt = ninit_r - 1'b1;
					cnt_nxt = CNT_W'(RFC_CYCLES - 1);
				end
			end
			ST_MODE: if (cnt_r == '0) begin
				ready_nxt = 1'b1;
				st_nxt = ST_IDLE;
			end
			ST_IDLE: begin
				// Refresh goes ahead of a waiting request so the part never misses its interval.
				if (due_r) begin
					cmd_nxt = CMD_REFRESH;
					due_nxt = ref_cnt_r == '0;
					cnt_nxt = CNT_W'(RFC_CYCLES - 1);
					st_nxt = ST_RECOVER;
				end else if (new_req) begin
					seen_nxt = req_s3_r;
					rd_pend_nxt = !hold_r.write;
					dout_nxt = hold_r.wdata;
					if (hold_r.is_static) begin
						addr_nxt = hold_r.addr;
						cs_n_nxt = ~(5'h01 << hold_r.region);
						doe_nxt = hold_r.write;
						wr_n_nxt = !hold_r.write;
						rd_n_nxt = hold_r.write;
						bls_nxt = LANE_RESET;
						cnt_nxt = CNT_W'(STATIC_CYCLES - 1);
						st_nxt = ST_STATIC;
					end else begin
						cmd_nxt = CMD_ACTIVE;
						addr_nxt = sdram_addr(hold_r.addr[20:9], hold_r.addr[22:21]);
						cnt_nxt = CNT_W'(RCD_CYCLES - 1);
						st_nxt = ST_ACTIVATE;
					end
				end
			end
			ST_ACTIVATE: if (cnt_r == '0) begin
				addr_nxt = sdram_addr({3'h1, 1'b0, hold_r.addr[8:1]}, hold_r.addr[22:21]);
				addr_nxt[SDRAM_ADDR_LSB + AUTO_PRE_BIT] = 1'b1;
				if (hold_r.write) begin
					cmd_nxt = CMD_WRITE;
					doe_nxt = 1'b1;
					bls_nxt = ~hold_r.byte_en;
					ack_nxt = ~ack_r;
					cnt_nxt = CNT_W'(WR_CYCLES + RP_CYCLES - 1);
					st_nxt = ST_RECOVER;
				end else begin
					cmd_nxt = CMD_READ;
					bls_nxt = LANE_RESET;
					cnt_nxt = CNT_W'(CAS_LATENCY);
					st_nxt = ST_RD_LAT;
				end
			end
			ST_RD_LAT: if (cnt_r == '0) begin
				rdata_nxt = mem_data_in;
				ack_nxt = ~ack_r;
				cnt_nxt = CNT_W'(RP_CYCLES - 1);
				st_nxt = ST_RECOVER;
			end
			ST_STATIC: begin
				if (cnt_r == '0) begin
					rdata_nxt = rd_pend_r ? mem_data_in : rdata_r;
					ack_nxt = ~ack_r;
					st_nxt = ST_IDLE;
				end else begin
					cs_n_nxt = cs_n_r;
					rd_n_nxt = rd_n_r;
					wr_n_nxt = wr_n_r;
					doe_nxt = doe_r;
				end
			end
			ST_RECOVER: if (cnt_r == '0) begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge proc_clock_in or negedge lrst_n_r) begin
		if (!lrst_n_r) begin
			st_r <= ST_POWER;
			cnt_r <= CNT_W'(READY_WAIT);
			ref_cnt_r <= REF_W'(REFRESH_CYCLES - 1);
			ninit_r <= 4'h0;
			due_r <= 1'b0;
			ready_r <= 1'b0;
			ack_r <= 1'b0;
			seen_r <= 1'b0;
			rd_pend_r <= 1'b0;
			cmd_r <= CMD_NOP;
			addr_r <= ADDR_RESET;
			dout_r <= DATA_RESET;
			rdata_r <= DATA_RESET;
			doe_r <= 1'b0;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			cs_n_r <= SELECT_IDLE;
			bls_r <= LANE_RESET;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			ref_cnt_r <= ref_cnt_nxt;
			ninit_r <= ninit_nxt;
			due_r <= due_nxt;
			ready_r <= ready_nxt;
			ack_r <= ack_nxt;
			seen_r <= seen_nxt;
			rd_pend_r <= rd_pend_nxt;
			cmd_r <= cmd_nxt;
			addr_r <= addr_nxt;
			dout_r <= dout_nxt;
			rdata_r <= rdata_nxt;
			doe_r <= doe_nxt;
			rd_n_r <= rd_n_nxt;
			wr_n_r <= wr_n_nxt;
			cs_n_r <= cs_n_nxt;
			bls_r <= bls_nxt;
		end
	end

	// SDRAM states never touch the static strobes, which rest released.
	assign static_read_n = rd_n_r;
	assign static_write_n = wr_n_r;
	assign static_select_n = cs_n_r;
	assign row_strobe_n = cmd_r.ras_n;
	assign col_strobe_n = cmd_r.cas_n;
	assign read_not_write = cmd_r.rw_n;
	assign mem_addr = addr_r;
	assign mem_data_out = dout_r;
	assign mem_data_oe = doe_r;
	assign byte_lane_select = bls_r;

endmodule : external_memory_bus_port

`default_nettype wire

// ---- hdl/ext_mem_pkg.sv ----
// Constants and carriers shared by the external memory bus port.
// Assumes a 40 MHz processor clock on the memory side and a faster system clock on the request side.
package ext_mem_pkg;

	localparam int PROC_CLK_MHZ = 40;
	localparam int SYS_CLK_MHZ = 200;

	// Time from reset release until the memory side may start the power-up sequence.
	localparam int READY_TIME_US = 2000;
	localparam int READY_CYCLES = READY_TIME_US * PROC_CLK_MHZ;

	// Longest spacing between two auto-refresh commands, rounded down.
	localparam int REFRESH_NS = 15600;
	localparam int REFRESH_CYCLES = (REFRESH_NS * PROC_CLK_MHZ) / 1000;

	localparam int T_RP_NS = 20;
	localparam int T_RCD_NS = 20;
	localparam int T_RFC_NS = 70;
	localparam int T_WR_NS = 15;
	localparam int STATIC_STROBE_NS = 100;

	function automatic int min_cycles(input int ns);
		int c;
		c = (ns * PROC_CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : min_cycles

	localparam int RP_CYCLES = min_cycles(T_RP_NS);
	localparam int RCD_CYCLES = min_cycles(T_RCD_NS);
	localparam int RFC_CYCLES = min_cycles(T_RFC_NS);
	localparam int WR_CYCLES = min_cycles(T_WR_NS);
	localparam int STATIC_CYCLES = min_cycles(STATIC_STROBE_NS);
	localparam int MRD_CYCLES = 2;
	localparam int CAS_LATENCY = 2;
	localparam int INIT_REFRESHES = 8;

	localparam int CNT_W = 17;
	localparam int REF_W = 10;

	// Burst length one, sequential, CAS latency two.
	localparam logic [11:0] MODE_WORD = 12'h020;
	// SDRAM address bit 10 asks for auto-precharge or precharge-all.
	localparam int AUTO_PRE_BIT = 10;
	// SDRAM address bits sit one place up on the device address bus.
	localparam int SDRAM_ADDR_LSB = 1;
	localparam int BANK_LSB = 13;

	localparam logic [4:0] SELECT_IDLE = 5'h1f;
	localparam logic [24:0] ADDR_RESET = 25'h0000000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [1:0] LANE_RESET = 2'h0;

	// SDRAM address layout: word address bits go out one place up on the bus.
	function automatic logic [24:0] sdram_addr(input logic [11:0] a, input logic [1:0] bank);
		logic [24:0] v;
		v = ADDR_RESET;
		v[SDRAM_ADDR_LSB +: 12] = a;
		v[BANK_LSB +: 2] = bank;
		return v;
	endfunction : sdram_addr

	typedef struct packed {
		logic write;
		logic is_static;
		logic [2:0] region;
		logic [24:0] addr;
		logic [15:0] wdata;
		logic [1:0] byte_en;
	} mem_req_t;

	typedef struct packed {
		logic ras_n;
		logic cas_n;
		logic rw_n;
	} sdram_cmd_t;

	localparam sdram_cmd_t CMD_NOP = 3'b111;
	localparam sdram_cmd_t CMD_ACTIVE = 3'b011;
	localparam sdram_cmd_t CMD_READ = 3'b101;
	localparam sdram_cmd_t CMD_WRITE = 3'b100;
	localparam sdram_cmd_t CMD_PRECHARGE = 3'b010;
	localparam sdram_cmd_t CMD_REFRESH = 3'b001;
	localparam sdram_cmd_t CMD_MODE = 3'b000;

endpackage : ext_mem_pkg

// ---- dv/ext_mem_properties.sv ----
// Pin checker for the external memory bus port, link clock domain.
// Assumes it is bound into external_memory_bus_port.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_checker
	import ext_mem_pkg::*;
(
	input wire logic rst_n,
	input wire logic proc_clock_in,
	input wire logic [24:0] mem_addr,
	input wire logic mem_data_oe,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic read_not_write,
	input wire logic static_read_n,
	input wire logic static_write_n,
	input wire logic [4:0] static_select_n,
	input wire logic [1:0] byte_lane_select
);
	sdram_cmd_t cmd;
	assign cmd = {row_strobe_n, col_strobe_n, read_not_write};
	default clocking @(posedge proc_clock_in); endclocking
	default disable iff (!rst_n);
	sequence access_s;
		cmd == CMD_READ || cmd == CMD_WRITE;
	endsequence
	sequence read_held_s;
		!static_read_n [*4];
	endsequence
	chk_sdram_keeps_static: assert property (cmd != CMD_NOP |-> static_read_n && static_write_n
		&& static_select_n == SELECT_IDLE) else $error("static pins active in SDRAM cycle");
	chk_one_select: assert property (static_select_n != SELECT_IDLE |-> $onehot(~static_select_n))
		else $error("more than one select low");
	chk_strobe_select: assert property (!static_read_n || !static_write_n |->
		static_select_n != SELECT_IDLE && static_read_n != static_write_n) else $error("bad static strobes");
	chk_read_hold: assert property ($fell(static_read_n) |-> read_held_s ##1 static_read_n)
		else $error("read strobe width wrong");
	chk_write_drives: assert property ($fell(static_write_n) |-> mem_data_oe [*4] ##1 !mem_data_oe)
		else $error("write data not driven with strobe");
	chk_active_first: assert property (access_s |-> $past(cmd) == CMD_ACTIVE)
		else $error("access without active");
	chk_write_cmd_oe: assert property (cmd == CMD_WRITE |-> mem_data_oe)
		else $error("write command without data");
	chk_read_cmd: assert property (cmd == CMD_READ |-> !mem_data_oe && byte_lane_select == 2'h0
		&& mem_addr[11]) else $error("read command pins wrong");
	chk_oe_cause: assert property (mem_data_oe |-> cmd == CMD_WRITE || !static_write_n)
		else $error("bus driven outside a write");
endmodule : ext_mem_checker
bind external_memory_bus_port ext_mem_checker chk_u (.rst_n, .proc_clock_in, .mem_addr, .mem_data_oe,
	.row_strobe_n, .col_strobe_n, .read_not_write, .static_read_n, .static_write_n, .static_select_n,
	.byte_lane_select);
`default_nettype wire

// ---- dv/mem_model.sv ----
// Behavioural SDRAM plus five static parts sharing one word store.
// Assumes it is clocked by the forwarded memory clock.
`timescale 1ns/1ps
`default_nettype none
module mem_model
	import ext_mem_pkg::*;
(
	input wire logic mem_clk,
	input wire logic [24:0] mem_addr,
	input wire logic [15:0] mem_data_out,
	input wire logic mem_data_oe,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic read_not_write,
	input wire logic static_read_n,
	input wire logic static_write_n,
	input wire logic [4:0] static_select_n,
	input wire logic [1:0] byte_lane_select,
	output logic [15:0] mem_data_in
);
	logic [15:0] mem [logic [28:0]];
	logic [11:0] row [4];
	logic [28:0] rd_key;
	logic [1:0] rd_cnt = 2'h0;
	logic [15:0] last = 16'h0;
	logic pre_seen = 1'b0;
	logic mode_ok = 1'b0;
	int n_ref = 0;
	sdram_cmd_t cmd;
	assign cmd = {row_strobe_n, col_strobe_n, read_not_write};
	function automatic logic [28:0] skey();
		return {7'h0, mem_addr[14:13], row[mem_addr[14:13]], mem_addr[8:1]};
	endfunction : skey
	function automatic logic [28:0] pkey();
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < 5; i++) if (!static_select_n[i]) r = 3'(i);
		return {1'b1, r, mem_addr};
	endfunction : pkey
	always @(posedge mem_clk) begin
		rd_cnt <= (rd_cnt != 2'h0) ? rd_cnt - 2'h1 : 2'h0;
		last <= mem_data_in;
		if (cmd == CMD_PRECHARGE) pre_seen <= 1'b1;
		if (cmd == CMD_REFRESH) n_ref <= n_ref + 1;
		if (cmd == CMD_MODE) mode_ok <= pre_seen && n_ref >= INIT_REFRESHES && mem_addr[12:1] == MODE_WORD;
		if (cmd == CMD_ACTIVE) row[mem_addr[14:13]] <= mem_addr[12:1];
		if (cmd == CMD_READ) begin
			rd_key <= skey();
			rd_cnt <= 2'h2;
		end
		if (cmd == CMD_WRITE && !byte_lane_select[0]) mem[skey()][7:0] = mem_data_out[7:0];
		if (cmd == CMD_WRITE && !byte_lane_select[1]) mem[skey()][15:8] = mem_data_out[15:8];
		if (!static_write_n) mem[pkey()] = mem_data_out;
	end
	// A released bus toggles so that a design sampling at the wrong edge cannot read a stale match.
	always_comb begin
		if (mem_data_oe) mem_data_in = mem_data_out;
		else if (!static_read_n) mem_data_in = mem[pkey()];
		else if (rd_cnt == 2'h1) mem_data_in = mem[rd_key];
		else mem_data_in = ~last;
	end
endmodule : mem_model
`default_nettype wire

// ---- dv/external_memory_bus_port_tb.sv ----
// Self-checking bench for the external memory bus port.
// Assumes the memory model on the bus and the bound pin checker.
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_port_tb
	import ext_mem_pkg::*;
;
	localparam int WAIT_CYC = 20;
	logic clk = 1'b0, proc_clock_in = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
	mem_req_t req = '0;
	logic req_ready, resp_valid, mem_ready, proc_clock_out, mem_data_oe, row_strobe_n, col_strobe_n;
	logic read_not_write, static_read_n, static_write_n;
	logic [15:0] resp_rdata, mem_data_in, mem_data_out;
	logic [24:0] mem_addr;
	logic [4:0] static_select_n;
	logic [1:0] byte_lane_select;
	logic [15:0] ref_mem [logic [28:0]];
	int n_errors = 0, n_tests = 0, cycles = 0;
	always #2.5 clk = ~clk;
	always #32 proc_clock_in = ~proc_clock_in;
	external_memory_bus_port #(.READY_WAIT(WAIT_CYC)) dut_u (.clk, .rst_n, .req_valid, .req, .req_ready,
		.resp_valid, .resp_rdata, .mem_ready, .proc_clock_in, .proc_clock_out, .mem_addr, .mem_data_in,
		.mem_data_out, .mem_data_oe, .row_strobe_n, .col_strobe_n, .read_not_write, .static_read_n,
		.static_write_n, .static_select_n, .byte_lane_select);
	mem_model mdl_u (.mem_clk(proc_clock_out), .mem_addr, .mem_data_out, .mem_data_oe, .row_strobe_n,
		.col_strobe_n, .read_not_write, .static_read_n, .static_write_n, .static_select_n,
		.byte_lane_select, .mem_data_in);
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic access(input logic wr, st, input logic [2:0] rg, input logic [24:0] a,
		input logic [15:0] wd, input logic [1:0] be, output logic [15:0] rd);
		@(posedge clk);
		req <= '{wr, st, rg, a, wd, be};
		req_valid <= 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		do @(posedge clk); while (resp_valid !== 1'b1);
		rd = resp_rdata;
	endtask : access
	// Expected word merges lanes here so the model's store is judged against an independent copy.
	function automatic logic [15:0] merge_lanes(input logic [15:0] prev, input logic [15:0] d, input logic [1:0] en);
		logic [15:0] v;
		v = prev;
		if (en[0]) v[7:0] = d[7:0];
		if (en[1]) v[15:8] = d[15:8];
		return v;
	endfunction : merge_lanes
	task automatic wr_rd(input logic st, input logic [2:0] rg, input logic [24:0] a, input logic [15:0] d,
		input logic [1:0] be);
		logic [28:0] k;
		logic [15:0] e, got;
		k = st ? {1'b1, rg, a} : {7'h0, a[22:1]};
		e = merge_lanes(ref_mem.exists(k) ? ref_mem[k] : 16'h0, d, st ? 2'h3 : be);
		ref_mem[k] = e;
		access(1'b1, st, rg, a, d, be, got);
		// The SDRAM takes the word one memory clock after the write command, later than the response.
		repeat (2) @(posedge proc_clock_in);
		check("stored word", e, mdl_u.mem[k]);
		access(1'b0, st, rg, a, 16'h0, 2'h3, got);
		check("read data", e, got);
	endtask : wr_rd
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		int t;
		logic st;
		logic [24:0] a;
		t = $urandom(22181);
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t = 0;
		while (mem_ready !== 1'b1) begin
			@(posedge proc_clock_in);
			t++;
		end
		check("ready wait", 1, t >= WAIT_CYC + INIT_REFRESHES * RFC_CYCLES);
		check("power-up order", 1, mdl_u.mode_ok);
		#3 check("clock out", proc_clock_in, proc_clock_out);
		#40 check("clock out", proc_clock_in, proc_clock_out);
		wr_rd(1'b0, 3'h0, 25'h0, 16'hffff, 2'h3);
		wr_rd(1'b0, 3'h0, 25'h7ffffe, 16'h8001, 2'h3);
		for (int b = 1; b < 3; b++) wr_rd(1'b0, 3'h0, 25'h7ffffe, 16'h5aa5 ^ 16'(b), 2'(b));
		for (int r = 0; r < 5; r++) wr_rd(1'b1, 3'(r), 25'h1ffffff - 25'(r), 16'h1234 + 16'(r), 2'h3);
		repeat (40) begin
			st = 1'($urandom_range(1, 0));
			a = st ? 25'($urandom()) : {2'h0, 22'($urandom()), 1'b0};
			wr_rd(st, 3'($urandom_range(4, 0)), a, 16'($urandom()), 2'h3);
		end
		t = mdl_u.n_ref;
		repeat (700) @(posedge proc_clock_in);
		check("refresh count", 1, mdl_u.n_ref > t);
		complete_run();
	end
endmodule : external_memory_bus_port_tb
`default_nettype wire
